// [logic/lvad_pkg.sv]
// Constants for the legacy video address decoder.
`default_nettype none
package lvad_pkg;
	// ==========================================================
	// Legacy I/O ports.
	localparam logic [15:0] IO_MONO_IDX  = 16'h03B4;
	localparam logic [15:0] IO_MONO_DAT  = 16'h03B5;
	localparam logic [15:0] IO_MONO_STAT = 16'h03BA;
	localparam logic [15:0] IO_STD_LO    = 16'h03C0;
	localparam logic [15:0] IO_STD_HI    = 16'h03CF;
	localparam logic [15:0] IO_ATTR_IDX  = 16'h03C0;
	localparam logic [15:0] IO_ATTR_DAT  = 16'h03C1;
	localparam logic [15:0] IO_STAT0     = 16'h03C2;
	localparam logic [15:0] IO_SEQ_IDX   = 16'h03C4;
	localparam logic [15:0] IO_SEQ_DAT   = 16'h03C5;
	localparam logic [15:0] IO_PAL_MASK  = 16'h03C6;
	localparam logic [15:0] IO_FEAT_RD   = 16'h03CA;
	localparam logic [15:0] IO_MISC_RD   = 16'h03CC;
	localparam logic [15:0] IO_GFX_IDX   = 16'h03CE;
	localparam logic [15:0] IO_GFX_DAT   = 16'h03CF;
	localparam logic [15:0] IO_PNL_IDX   = 16'h03D0;
	localparam logic [15:0] IO_PNL_DAT   = 16'h03D1;
	localparam logic [15:0] IO_MM_IDX    = 16'h03D2;
	localparam logic [15:0] IO_MM_DAT    = 16'h03D3;
	localparam logic [15:0] IO_COL_IDX   = 16'h03D4;
	localparam logic [15:0] IO_COL_DAT   = 16'h03D5;
	localparam logic [15:0] IO_XT_IDX    = 16'h03D6;
	localparam logic [15:0] IO_XT_DAT    = 16'h03D7;
	localparam logic [15:0] IO_COL_STAT  = 16'h03DA;
	localparam logic [15:0] IO_COL_X_HI  = 16'h03DC;
	// ==========================================================
	// Legacy memory ranges.
	localparam logic [31:0] MEM_WIN_LO  = 32'h000A0000;
	localparam logic [31:0] MEM_WIN_HI  = 32'h000AFFFF;
	localparam logic [31:0] MEM_MONO_LO = 32'h000B0000;
	localparam logic [31:0] MEM_MONO_HI = 32'h000B7FFF;
	localparam logic [31:0] MEM_COL_LO  = 32'h000B8000;
	localparam logic [31:0] MEM_COL_HI  = 32'h000BFFFF;
	// ==========================================================
	// Sub-addressed register groups.
	localparam logic [2:0] GRP_ATTR = 3'h0;
	localparam logic [2:0] GRP_SEQ  = 3'h1;
	localparam logic [2:0] GRP_GFX  = 3'h2;
	localparam logic [2:0] GRP_PNL  = 3'h3;
	localparam logic [2:0] GRP_MM   = 3'h4;
	localparam logic [2:0] GRP_CRTC = 3'h5;
	localparam logic [2:0] GRP_XT   = 3'h6;
	localparam int          GRP_NUM  = 7;
	// ==========================================================
	// Read data sources.
	localparam logic [2:0] SRC_ZERO  = 3'h0;
	localparam logic [2:0] SRC_MEM   = 3'h1;
	localparam logic [2:0] SRC_IDX   = 3'h2;
	localparam logic [2:0] SRC_STAT0 = 3'h3;
	localparam logic [2:0] SRC_STAT1 = 3'h4;
	localparam logic [2:0] SRC_MISC  = 3'h5;
	localparam logic [2:0] SRC_FEAT  = 3'h6;
	localparam logic [2:0] SRC_PALM  = 3'h7;
	// ==========================================================
	// Reset values and frame buffer geometry.
	localparam logic [7:0] MISC_RST     = 8'h00;
	localparam logic [7:0] FEAT_RST     = 8'h00;
	localparam logic [7:0] PAL_MASK_RST = 8'hFF;
	localparam logic [7:0] IDX_RST      = 8'h00;
	localparam int         WIN_OFS_W    = 16;
	localparam int         TXT_OFS_W    = 15;
	localparam int         LFB_OFS_W    = 24;
	localparam int         FB_AW_DEF    = 22;
	localparam int         BANK_W_DEF   = 6;
endpackage
`default_nettype wire

// [logic/lvad_rf_if.sv]
// Carrier between the decoder and its indexed register store.
`timescale 1ns/1ps
`default_nettype none
interface lvad_rf_if #(
	parameter int AW = 11,
	parameter int DW = 8
);
	logic          we;
	logic          re;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport ctl (output we, output re, output addr, output wdata,
		input rdata);
	modport mem (input we, input re, input addr, input wdata,
		output rdata);
endinterface
`default_nettype wire

// [logic/lvad_regmem.sv]
// Indexed register store with registered read data.
`timescale 1ns/1ps
`default_nettype none
module lvad_regmem #(
	parameter int AW = 11,
	parameter int DW = 8
) (
	input  wire logic sys_clk_in,
	input  wire logic ce_in,
	lvad_rf_if.mem    rf
);
	// ==========================================================
	// Storage.
	logic [DW-1:0] mem_q [0:(1<<AW)-1];
	logic [DW-1:0] rdata_q;

	// Write port; a same-cycle read returns the old word.
	always_ff @(posedge sys_clk_in) begin
		if (ce_in && rf.we) begin
			mem_q[rf.addr] <= rf.wdata;
		end
	end

	// Read port, registered so the store maps onto block memory.
	always_ff @(posedge sys_clk_in) begin
		if (ce_in && rf.re) begin
			rdata_q <= mem_q[rf.addr];
		end
	end

	assign rf.rdata = rdata_q;
endmodule
`default_nettype wire

// [logic/lvad_decode.sv]
// Legacy display I/O, window and linear aperture address decoder.
// ==========================================================
// Summary of operation
// - Index port selects register for data port.
// - Direct registers decoded by address and direction.
// - Monochrome mode claims 3B4-3B5, 3BA, B0000-B7FFF.
// - Colour mode claims 3D4-3D5, 3DA-3DC, B8000-BFFFF.
// - Always decode standard block 3C0-3CF.
// - A0000 window pages a 4MB buffer or planes 256KB.
// - Extension index/data pairs at 3D0-3D3, 3D6-3D7.
// - Frame buffer addressing reaches 4MB.
// - 16MB linear aperture at configured base.
// - Indexed registers read back stored value.
`timescale 1ns/1ps
`default_nettype none
module lvad_decode #(
	parameter int FB_AW  = lvad_pkg::FB_AW_DEF,
	parameter int BANK_W = lvad_pkg::BANK_W_DEF
) (
	input  wire logic             sys_clk_in,
	input  wire logic             resetn_in,
	input  wire logic             ce_in,
	input  wire logic             io_req_in,
	input  wire logic             mem_req_in,
	input  wire logic             wr_in,
	input  wire logic [31:0]      addr_in,
	input  wire logic [7:0]       wdata_in,
	input  wire logic             mono_mode_in,
	input  wire logic [7:0]       lfb_base_in,
	input  wire logic [BANK_W-1:0] bank_in,
	input  wire logic             planar_in,
	input  wire logic [3:0]       plane_mask_in,
	input  wire logic [7:0]       stat0_in,
	input  wire logic [7:0]       stat1_in,
	output logic                  claim_out,
	output logic                  rvalid_out,
	output logic [7:0]            rdata_out,
	output logic                  fb_valid_out,
	output logic [FB_AW-1:0]      fb_addr_out,
	output logic [3:0]            fb_plane_out,
	output logic [7:0]            misc_out,
	output logic [7:0]            feat_out,
	output logic [7:0]            pal_mask_out
);
	// ==========================================================
	// Types and helpers.
	typedef enum logic [1:0] {
		LVAD_ATTR_INDEX = 2'b01,
		LVAD_ATTR_DATA  = 2'b10
	} lvad_attr_t;

	// Inclusive range test, used for the standard port block and the window and text ranges.
	function automatic logic in_rng(input logic [31:0] a,
		input logic [31:0] lo, input logic [31:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	// Byte offset within the window, zero-extended to buffer width.
	function automatic logic [FB_AW-1:0] ofs_ext(
		input logic [31:0] a, input int w);
		logic [31:0] m;
		m = (32'h00000001 << w) - 32'h00000001;
		ofs_ext = FB_AW'(a & m);
	endfunction

	localparam int RF_AW = 11;

	lvad_rf_if #(.AW(RF_AW), .DW(8)) rf ();

	lvad_regmem #(.AW(RF_AW), .DW(8)) u_regmem (
		.sys_clk_in (sys_clk_in),
		.ce_in      (ce_in),
		.rf         (rf.mem)
	);

	// ==========================================================
	// Combinational I/O decode.
	logic [15:0] a16;
	logic        io_ok;
	logic        io_hit;
	logic        is_idx;
	logic        is_dat;
	logic [2:0]  grp;
	logic [2:0]  src_rd;
	logic        misc_we;
	logic        feat_we;
	logic        palm_we;
	logic        stat1_rd;
	logic        attr_alt;

	assign a16   = addr_in[15:0];
	assign io_ok = io_req_in && (addr_in[31:16] == 16'h0000);

	// Every claimed port resolves to a group role, a direct register or no register.
	always_comb begin
		io_hit   = 1'b0;
		is_idx   = 1'b0;
		is_dat   = 1'b0;
		grp      = lvad_pkg::GRP_ATTR;
		src_rd   = lvad_pkg::SRC_ZERO;
		misc_we  = 1'b0;
		feat_we  = 1'b0;
		palm_we  = 1'b0;
		stat1_rd = 1'b0;
		attr_alt = 1'b0;
		if (in_rng({16'h0000, a16}, {16'h0000, lvad_pkg::IO_STD_LO},
			{16'h0000, lvad_pkg::IO_STD_HI})) begin
			io_hit = 1'b1;
		end
		case (a16)
		lvad_pkg::IO_MONO_IDX, lvad_pkg::IO_COL_IDX: begin
			// Only the selected emulation owns its CRTC pair.
			io_hit = mono_mode_in == (a16 == lvad_pkg::IO_MONO_IDX);
			is_idx = 1'b1;
			grp    = lvad_pkg::GRP_CRTC;
		end
		lvad_pkg::IO_MONO_DAT, lvad_pkg::IO_COL_DAT: begin
			io_hit = mono_mode_in == (a16 == lvad_pkg::IO_MONO_DAT);
			is_dat = 1'b1;
			grp    = lvad_pkg::GRP_CRTC;
		end
		lvad_pkg::IO_MONO_STAT, lvad_pkg::IO_COL_STAT: begin
			io_hit = mono_mode_in == (a16 == lvad_pkg::IO_MONO_STAT);
			// Status reads, feature control writes here.
			src_rd   = lvad_pkg::SRC_STAT1;
			feat_we  = wr_in;
			stat1_rd = !wr_in;
		end
		lvad_pkg::IO_ATTR_IDX: begin
			is_idx = 1'b1;
			grp    = lvad_pkg::GRP_ATTR;
		end
		lvad_pkg::IO_ATTR_DAT: begin
			is_dat   = 1'b1;
			grp      = lvad_pkg::GRP_ATTR;
			attr_alt = 1'b1;
		end
		lvad_pkg::IO_STAT0: begin
			src_rd  = lvad_pkg::SRC_STAT0;
			misc_we = wr_in;
		end
		lvad_pkg::IO_SEQ_IDX: begin
			is_idx = 1'b1;
			grp    = lvad_pkg::GRP_SEQ;
		end
		lvad_pkg::IO_SEQ_DAT: begin
			is_dat = 1'b1;
			grp    = lvad_pkg::GRP_SEQ;
		end
		lvad_pkg::IO_PAL_MASK: begin
			src_rd  = lvad_pkg::SRC_PALM;
			palm_we = wr_in;
		end
		lvad_pkg::IO_FEAT_RD: begin
			src_rd = wr_in ? lvad_pkg::SRC_ZERO : lvad_pkg::SRC_FEAT;
		end
		lvad_pkg::IO_MISC_RD: begin
			src_rd = wr_in ? lvad_pkg::SRC_ZERO : lvad_pkg::SRC_MISC;
		end
		lvad_pkg::IO_GFX_IDX: begin
			is_idx = 1'b1;
			grp    = lvad_pkg::GRP_GFX;
		end
		lvad_pkg::IO_GFX_DAT: begin
			is_dat = 1'b1;
			grp    = lvad_pkg::GRP_GFX;
		end
		lvad_pkg::IO_PNL_IDX, lvad_pkg::IO_MM_IDX,
		lvad_pkg::IO_XT_IDX: begin
			io_hit = 1'b1;
			is_idx = 1'b1;
			grp    = (a16 == lvad_pkg::IO_PNL_IDX) ? lvad_pkg::GRP_PNL :
				(a16 == lvad_pkg::IO_MM_IDX) ? lvad_pkg::GRP_MM :
				lvad_pkg::GRP_XT;
		end
		lvad_pkg::IO_PNL_DAT, lvad_pkg::IO_MM_DAT,
		lvad_pkg::IO_XT_DAT: begin
			io_hit = 1'b1;
			is_dat = 1'b1;
			grp    = (a16 == lvad_pkg::IO_PNL_DAT) ? lvad_pkg::GRP_PNL :
				(a16 == lvad_pkg::IO_MM_DAT) ? lvad_pkg::GRP_MM :
				lvad_pkg::GRP_XT;
		end
		default: begin
			// 3DB-3DC belong to colour mode but hold nothing.
			if (!mono_mode_in && (a16 > lvad_pkg::IO_COL_STAT) &&
				(a16 <= lvad_pkg::IO_COL_X_HI)) begin
				io_hit = 1'b1;
			end
		end
		endcase
		if (is_idx) begin
			src_rd = lvad_pkg::SRC_IDX;
		end
		if (is_dat) begin
			src_rd = lvad_pkg::SRC_MEM;
		end
		io_hit = io_hit && io_ok;
	end

	// ==========================================================
	// Index registers and the attribute flip-flop.
	logic [7:0] idx_q [0:lvad_pkg::GRP_NUM-1];
	lvad_attr_t attr_q;
	logic       attr_idx_wr;
	logic       dat_acc;

	// A write to 3C0 alternates between index and data.
	assign attr_idx_wr = io_hit && wr_in && is_idx &&
		(grp == lvad_pkg::GRP_ATTR) && (attr_q == LVAD_ATTR_INDEX);
	assign dat_acc = io_hit && (is_dat || (is_idx && wr_in &&
		(grp == lvad_pkg::GRP_ATTR) && (attr_q == LVAD_ATTR_DATA)));

	// Index capture; data port accesses then use the stored index.
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int g = 0; g < lvad_pkg::GRP_NUM; g++) begin
				idx_q[g] <= lvad_pkg::IDX_RST;
			end
		end else if (ce_in && io_hit && wr_in && is_idx) begin
			if (grp != lvad_pkg::GRP_ATTR || attr_idx_wr) begin
				idx_q[grp] <= wdata_in;
			end
		end
	end

	// Status 1 reads rearm the flip-flop so software can resync it.
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			attr_q <= LVAD_ATTR_INDEX;
		end else if (ce_in && io_hit) begin
			case (attr_q)
			LVAD_ATTR_INDEX: begin
				if (attr_idx_wr) begin
					attr_q <= LVAD_ATTR_DATA;
				end
			end
			LVAD_ATTR_DATA: begin
				if (stat1_rd || (wr_in && is_idx && !attr_alt &&
					grp == lvad_pkg::GRP_ATTR)) begin
					attr_q <= LVAD_ATTR_INDEX;
				end
			end
			default: begin
				attr_q <= LVAD_ATTR_INDEX;
			end
			endcase
		end
	end

	// Store access is addressed by group and stored index.
	assign rf.we    = dat_acc && wr_in && ce_in;
	assign rf.re    = dat_acc && !wr_in && ce_in;
	assign rf.addr  = {grp, idx_q[grp]};
	assign rf.wdata = wdata_in;

	// ==========================================================
	// Directly written registers.
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			misc_out     <= lvad_pkg::MISC_RST;
			feat_out     <= lvad_pkg::FEAT_RST;
			pal_mask_out <= lvad_pkg::PAL_MASK_RST;
		end else if (ce_in && io_hit) begin
			if (misc_we) begin
				misc_out <= wdata_in;
			end
			if (feat_we) begin
				feat_out <= wdata_in;
			end
			if (palm_we) begin
				pal_mask_out <= wdata_in;
			end
		end
	end

	// ==========================================================
	// Memory decode.
	logic             mw_hit;
	logic             mt_hit;
	logic             ml_hit;
	logic [FB_AW-1:0] m_addr;

	// The aperture base comes from the host's setup space.
	assign ml_hit = mem_req_in && (addr_in[31:24] == lfb_base_in);
	assign mw_hit = mem_req_in && in_rng(addr_in, lvad_pkg::MEM_WIN_LO,
		lvad_pkg::MEM_WIN_HI);
	assign mt_hit = mem_req_in && (mono_mode_in ?
		in_rng(addr_in, lvad_pkg::MEM_MONO_LO, lvad_pkg::MEM_MONO_HI) :
		in_rng(addr_in, lvad_pkg::MEM_COL_LO,
		lvad_pkg::MEM_COL_HI));

	// Paged mode stacks a bank above the 64KB offset; planar mode
	// leaves paging to the plane mask. The aperture wraps above 4MB.
	always_comb begin
		m_addr = '0;
		if (ml_hit) begin
			m_addr = ofs_ext(addr_in, lvad_pkg::LFB_OFS_W);
		end else if (mw_hit) begin
			m_addr = ofs_ext(addr_in, lvad_pkg::WIN_OFS_W);
			if (!planar_in) begin
				m_addr = m_addr | (FB_AW'(bank_in) <<
					lvad_pkg::WIN_OFS_W);
			end
		end else if (mt_hit) begin
			m_addr = ofs_ext(addr_in, lvad_pkg::TXT_OFS_W);
		end
	end

	// ==========================================================
	// Pipeline stage one: remember what the answer will be.
	logic       s1_claim_q;
	logic       s1_rd_q;
	logic [2:0] s1_src_q;
	logic [7:0] s1_idx_q;
	logic       s1_fb_q;
	logic [FB_AW-1:0] s1_addr_q;
	logic [3:0] s1_plane_q;

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s1_claim_q <= 1'b0;
			s1_rd_q    <= 1'b0;
			s1_src_q   <= lvad_pkg::SRC_ZERO;
			s1_idx_q   <= lvad_pkg::IDX_RST;
			s1_fb_q    <= 1'b0;
			s1_addr_q  <= '0;
			s1_plane_q <= 4'h0;
		end else if (ce_in) begin
			s1_claim_q <= io_hit || mw_hit || mt_hit || ml_hit;
			s1_rd_q    <= io_hit && !wr_in;
			s1_src_q   <= src_rd;
			s1_idx_q   <= idx_q[grp];
			s1_fb_q    <= mw_hit || mt_hit || ml_hit;
			s1_addr_q  <= m_addr;
			// Planar window writes may hit several planes at once.
			s1_plane_q <= (mw_hit && planar_in) ? plane_mask_in :
				4'hF;
		end
	end

	// ==========================================================
	// Stage two: registered answer at the top-level ports.
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			claim_out    <= 1'b0;
			rvalid_out   <= 1'b0;
			rdata_out    <= 8'h00;
			fb_valid_out <= 1'b0;
			fb_addr_out  <= '0;
			fb_plane_out <= 4'h0;
		end else if (ce_in) begin
			claim_out    <= s1_claim_q;
			rvalid_out   <= s1_rd_q;
			fb_valid_out <= s1_fb_q;
			fb_addr_out  <= s1_addr_q;
			fb_plane_out <= s1_plane_q;
			case (s1_src_q)
			lvad_pkg::SRC_MEM:   rdata_out <= rf.rdata;
			lvad_pkg::SRC_IDX:   rdata_out <= s1_idx_q;
			lvad_pkg::SRC_STAT0: rdata_out <= stat0_in;
			lvad_pkg::SRC_STAT1: rdata_out <= stat1_in;
			lvad_pkg::SRC_MISC:  rdata_out <= misc_out;
			lvad_pkg::SRC_FEAT:  rdata_out <= feat_out;
			lvad_pkg::SRC_PALM:  rdata_out <= pal_mask_out;
			default:             rdata_out <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

// [dv/lvad_decode_checker.sv]
// Assertion checker for the legacy video address decoder.
`timescale 1ns/1ps
`default_nettype none
module lvad_decode_checker #(
	parameter int FB_AW  = lvad_pkg::FB_AW_DEF,
	parameter int BANK_W = lvad_pkg::BANK_W_DEF
) (
	input wire logic              sys_clk_in,
	input wire logic              resetn_in,
	input wire logic              ce_in,
	input wire logic              io_req_in,
	input wire logic              mem_req_in,
	input wire logic              wr_in,
	input wire logic [31:0]       addr_in,
	input wire logic              mono_mode_in,
	input wire logic [7:0]        lfb_base_in,
	input wire logic [BANK_W-1:0] bank_in,
	input wire logic              planar_in,
	input wire logic [3:0]        plane_mask_in,
	input wire logic              claim_out,
	input wire logic              rvalid_out,
	input wire logic              fb_valid_out,
	input wire logic [FB_AW-1:0]  fb_addr_out,
	input wire logic [3:0]        fb_plane_out
);
	// ==========
	// Request classes, decoded from the host side only.
	wire logic [15:0]      ioa = addr_in[15:0];
	wire logic             iok = io_req_in && !mem_req_in
		&& addr_in[31:16] == 16'h0000;
	wire logic             mok = mem_req_in && !io_req_in;
	wire logic             mio = iok && (ioa == 16'h03B4
		|| ioa == 16'h03B5 || ioa == 16'h03BA);
	wire logic             cio = iok && (ioa == 16'h03D4
		|| ioa == 16'h03D5 || (ioa >= 16'h03DA && ioa <= 16'h03DC));
	wire logic             sio = iok && ioa[15:4] == 12'h03C;
	wire logic             xio = iok && (ioa[15:2] == 14'h00F4
		|| ioa[15:1] == 15'h01EB);
	wire logic             win = mok && addr_in[31:16] == 16'h000A;
	wire logic             lfb = mok && addr_in[31:24] == lfb_base_in;
	wire logic             txt = mok && addr_in[31:16] == 16'h000B;
	wire logic [FB_AW-1:0] pg  = FB_AW'({bank_in, addr_in[15:0]});
	wire logic [FB_AW-1:0] lo  = addr_in[FB_AW-1:0];
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);
	// ==========
	// An enabled edge takes the request, two enabled edges give the answer.
	sequence s_took(c);
		ce_in && c ##1 ce_in;
	endsequence
	a_std_claim: assert property (s_took(sio) |-> ##1 claim_out)
		else $error("standard block access not claimed");
	a_mono_claim: assert property (
		s_took(mio && mono_mode_in) |-> ##1 claim_out)
		else $error("mono port not claimed");
	a_col_claim: assert property (
		s_took(cio && !mono_mode_in) |-> ##1 claim_out)
		else $error("colour port not claimed");
	a_mono_skip: assert property (
		s_took(cio && mono_mode_in) |-> ##1 !claim_out)
		else $error("colour port claimed");
	a_col_skip: assert property (
		s_took(mio && !mono_mode_in) |-> ##1 !claim_out)
		else $error("mono port claimed");
	a_text_skip: assert property (
		s_took(txt && addr_in[15] == mono_mode_in)
		|-> ##1 !claim_out)
		else $error("idle text range claimed");
	a_ext_claim: assert property (s_took(xio) |-> ##1 claim_out)
		else $error("extension pair not claimed");
	a_write_no_data: assert property (
		s_took(iok && wr_in) |-> ##1 !rvalid_out)
		else $error("write gave read data");
	a_read_data: assert property (
		s_took(sio && !wr_in) |-> ##1 rvalid_out)
		else $error("read gave no data");
	a_page_addr: assert property (
		s_took(win && !planar_in)
		|-> ##1 fb_valid_out && fb_addr_out == $past(pg, 2))
		else $error("paged window address wrong");
	a_plane_sel: assert property (
		s_took(win && planar_in)
		|-> ##1 fb_plane_out == $past(plane_mask_in, 2))
		else $error("plane enables wrong");
	a_lfb_addr: assert property (
		s_took(lfb)
		|-> ##1 fb_valid_out && fb_addr_out == $past(lo, 2))
		else $error("aperture address wrong");
endmodule
bind lvad_decode lvad_decode_checker #(.FB_AW(FB_AW), .BANK_W(BANK_W))
	chk_i (.sys_clk_in, .resetn_in, .ce_in, .io_req_in, .mem_req_in,
	.wr_in, .addr_in, .mono_mode_in, .lfb_base_in, .bank_in, .planar_in,
	.plane_mask_in, .claim_out, .rvalid_out, .fb_valid_out, .fb_addr_out,
	.fb_plane_out);
`default_nettype wire

// [dv/lvad_host_model.sv]
// Host bus model that issues one decoder request at a time.
`timescale 1ns/1ps
`default_nettype none
module lvad_host_model (
	input  wire logic   sys_clk_in,
	output logic        io_req_out,
	output logic        mem_req_out,
	output logic        wr_out,
	output logic [31:0] addr_out,
	output logic [7:0]  wdata_out
);
	// ==========
	// Idle bus at start; lines get junk so stale values never match.
	initial begin
		io_req_out = 1'b0;
		mem_req_out = 1'b0;
		wr_out = 1'b0;
		addr_out = 32'hFFFFFFFF;
		wdata_out = 8'hFF;
	end
	// One request over one edge; returns just after the answer edge.
	task automatic xfer(input logic io, input logic w,
		input logic [31:0] a, input logic [7:0] d);
		io_req_out = io;
		mem_req_out = !io;
		wr_out = w;
		addr_out = a;
		wdata_out = d;
		@(posedge sys_clk_in);
		#1;
		io_req_out = 1'b0;
		mem_req_out = 1'b0;
		wr_out = !w;
		addr_out = ~a;
		wdata_out = ~d;
		// The answer is launched by the next edge and stands one cycle.
		@(posedge sys_clk_in);
		#1;
	endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the legacy video address decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
	n_tests++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("wrong value at %0t: %h vs %h", $time, (g), (e)); \
	end \
end
module tb_top;
	logic        sys_clk_in, resetn_in, io_req, mem_req, wr, mono, planar;
	logic        claim, rvalid, fb_valid, ce;
	logic [31:0] addr;
	logic [7:0]  wdata, lfb_base, stat0, stat1, rdata, misc, feat, pal;
	logic [5:0]  bank;
	logic [3:0]  pmask, fb_plane;
	logic [21:0] fb_addr;
	int          n_tests, bad_count;
	localparam logic [15:0] IDX_P [6] = '{16'h03C4, 16'h03CE, 16'h03D0,
		16'h03D2, 16'h03D6, 16'h03D4};
	lvad_decode lvad_decode_i (.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in), .ce_in(ce), .io_req_in(io_req),
		.mem_req_in(mem_req), .wr_in(wr), .addr_in(addr),
		.wdata_in(wdata), .mono_mode_in(mono), .lfb_base_in(lfb_base),
		.bank_in(bank), .planar_in(planar), .plane_mask_in(pmask),
		.stat0_in(stat0), .stat1_in(stat1), .claim_out(claim),
		.rvalid_out(rvalid), .rdata_out(rdata), .fb_valid_out(fb_valid),
		.fb_addr_out(fb_addr), .fb_plane_out(fb_plane), .misc_out(misc),
		.feat_out(feat), .pal_mask_out(pal));
	lvad_host_model lvad_host_model_i (.sys_clk_in(sys_clk_in),
		.io_req_out(io_req), .mem_req_out(mem_req), .wr_out(wr),
		.addr_out(addr), .wdata_out(wdata));
	// ==========
	// Bus cycles.
	task automatic wrp(input logic [15:0] a, input logic [7:0] d);
		lvad_host_model_i.xfer(1'b1, 1'b1, {16'h0000, a}, d);
	endtask
	task automatic rdp(input logic [15:0] a);
		lvad_host_model_i.xfer(1'b1, 1'b0, {16'h0000, a}, 8'h00);
	endtask
	task automatic mrd(input logic [31:0] a);
		lvad_host_model_i.xfer(1'b0, 1'b0, a, 8'h00);
	endtask
	// ==========
	// Scenarios.
	task automatic t_pairs();
		for (int i = 0; i < 6; i++) begin
			wrp(IDX_P[i], 8'h10 + 8'(i));
			wrp(IDX_P[i] + 16'h0001, 8'hA0 + 8'(i));
		end
		// Read back late so an ignored index would show.
		for (int i = 0; i < 6; i++) begin
			wrp(IDX_P[i], 8'h10 + 8'(i));
			rdp(IDX_P[i] + 16'h0001);
			`CHK(rvalid, 1'b1)
			`CHK(rdata, 8'hA0 + 8'(i))
			rdp(IDX_P[i]);
			`CHK(rdata, 8'h10 + 8'(i))
		end
	endtask
	task automatic t_direct();
		`CHK(pal, 8'hFF)
		wrp(16'h03C2, 8'h67);
		`CHK(rvalid, 1'b0)
		rdp(16'h03CC);
		`CHK(rdata, 8'h67)
		rdp(16'h03C2);
		`CHK(rdata, stat0)
		wrp(16'h03CC, 8'h11);
		`CHK(misc, 8'h67)
		wrp(16'h03DA, 8'h0B);
		`CHK(feat, 8'h0B)
		rdp(16'h03CA);
		`CHK(rdata, 8'h0B)
		wrp(16'h03C6, 8'h3C);
		rdp(16'h03C6);
		`CHK(rdata, 8'h3C)
	endtask
	task automatic t_hold();
		// A request made while the block is frozen must leave no trace.
		ce = 1'b0;
		wrp(16'h03C2, 8'h55);
		`CHK(misc, 8'h67)
		ce = 1'b1;
		rdp(16'h03CC);
		`CHK(rdata, 8'h67)
	endtask
	task automatic t_modes();
		// A refused index write must leave the colour index alone.
		wrp(16'h03B4, 8'h00);
		rdp(16'h03D5);
		`CHK(rdata, 8'hA5)
		for (int m = 0; m < 2; m++) begin
			mono = 1'(m);
			for (int k = 0; k < 5; k++) begin
				rdp(16'h03D4 + 16'(k < 2 ? k : k + 4));
				`CHK(claim, !mono)
			end
			rdp(16'h03BA);
			`CHK(claim, mono)
			mrd(32'h000B0010);
			`CHK(fb_valid, mono)
			mrd(32'h000B8010);
			`CHK(fb_valid, !mono)
			rdp(16'h03C3);
			`CHK(claim, 1'b1)
		end
		rdp(16'h03BA);
		`CHK(rdata, stat1)
	endtask
	task automatic t_mem();
		mono = 1'b0;
		bank = 6'h03;
		mrd(32'h000A1234);
		`CHK(fb_addr, 22'h031234)
		`CHK(fb_plane, 4'hF)
		bank = 6'h3F;
		mrd(32'h000AFFFF);
		`CHK(fb_addr, 22'h3FFFFF)
		planar = 1'b1;
		pmask = 4'h5;
		mrd(32'h000A0000);
		`CHK(fb_plane, 4'h5)
		mrd(32'h000B8123);
		`CHK(fb_addr, 22'h000123)
		mrd(32'h000C0000);
		`CHK(claim, 1'b0)
		mrd(32'hE4C00001);
		`CHK(fb_addr, 22'h000001)
		mrd(32'hE5000000);
		`CHK(claim, 1'b0)
		lvad_host_model_i.xfer(1'b0, 1'b1, 32'hE43FFFF0, 8'h5A);
		`CHK(fb_addr, 22'h3FFFF0)
	endtask
	task automatic t_attr();
		rdp(16'h03DA);
		wrp(16'h03C0, 8'h03);
		wrp(16'h03C0, 8'h5A);
		rdp(16'h03C1);
		`CHK(rdata, 8'h5A)
		wrp(16'h03C0, 8'h04);
		wrp(16'h03C1, 8'h6B);
		rdp(16'h03C0);
		`CHK(rdata, 8'h04)
		// The data-port write did not toggle, so this is data again.
		wrp(16'h03C0, 8'h7E);
		rdp(16'h03C1);
		`CHK(rdata, 8'h7E)
	endtask
	// ==========
	// Verdict, reached from the main sequence or the watchdog.
	task automatic final_report();
		$display("checks %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Free-running clock at 125 MHz.
	initial begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	// Main sequence: reset for 8 cycles, then each scenario in turn.
	initial begin
		{resetn_in, mono, planar, bank} = '0;
		ce = 1'b1;
		{lfb_base, pmask, stat0, stat1} = {8'hE4, 4'hF, 8'h3C, 8'h09};
		n_tests = 0;
		bad_count = 0;
		repeat (8) @(posedge sys_clk_in);
		#1;
		resetn_in = 1'b1;
		t_pairs();
		t_direct();
		t_hold();
		t_modes();
		t_mem();
		t_attr();
		final_report();
	end
	// Bounded watchdog so a hang still reaches the verdict.
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		bad_count++;
		final_report();
	end
endmodule
`default_nettype wire
